// file: src/cilr_top.sv
// I2C slave register bank with the input current limit register
//
// Behaviour
// - Every register is eight bits, bit 0 least significant, bit 7 most.
// - Answer only I2C transfers to seven-bit address 0x1a.
// - Register bank reset loads 0x17 into offset zero.
// - Bit 7 enables high impedance input; reset 0; disconnects supply pin.
// - Bits 6:5 pick status pin: 00 charge, 01 custom bits, else float.
// - Bits 4:0 code n means 100 plus 100 n milliamps.
// - Limit code resets to 10111, meaning 2400 milliamps.
// - Finished source detection writes its own code into the limit field; a host write to offset zero in that cycle wins.
// - Sixteen registers 0x00 to 0x0f; reads above 0x0f return 0xff.
// - Multi-byte access steps offset per byte, skipping 0x09 and 0x0e.
module cilr_top (
	input  wire logic                   ref_clk,
	input  wire logic                   rst,
	input  wire logic                   reg_reset,
	input  wire logic                   scl_in,
	input  wire logic                   sda_in,
	input  wire cilr_pkg::cilr_detect_t detect,
	input  wire logic                   charging_active,
	input  wire logic                   custom_status_on,
	output logic                        sda_out,
	output logic                        sda_oe_n,
	output logic                        stat_out,
	output logic                        stat_oe_n,
	output logic                        supply_disconnect,
	output cilr_pkg::cilr_icl_t         icl_out
);
	// Next register offset, stepping past fault and flag registers
	function automatic logic [7:0] step_offset(input logic [7:0] off);
		logic [7:0] nx;
		nx = off + 8'h01;
		if (nx == cilr_pkg::FAULT_OFFSET || nx == cilr_pkg::FLAG_OFFSET) begin
			nx = nx + 8'h01;
		end
		return nx;
	endfunction

	logic [2:0] scl_sync_reg;
	logic [2:0] sda_sync_reg;
	logic       scl_reg;
	logic       sda_reg;
	logic       scl_next;
	logic       sda_next;

	always_comb begin
		scl_next = scl_reg;
		sda_next = sda_reg;
		if (scl_sync_reg[1] == scl_sync_reg[2]) begin
			scl_next = scl_sync_reg[2];
		end
		if (sda_sync_reg[1] == sda_sync_reg[2]) begin
			sda_next = sda_sync_reg[2];
		end
	end

	always_ff @(posedge ref_clk) begin
		if (rst) begin
			scl_sync_reg <= 3'h7;
			sda_sync_reg <= 3'h7;
			scl_reg      <= 1'b1;
			sda_reg      <= 1'b1;
		end else begin
			scl_sync_reg <= {scl_sync_reg[1:0], scl_in};
			sda_sync_reg <= {sda_sync_reg[1:0], sda_in};
			scl_reg      <= scl_next;
			sda_reg      <= sda_next;
		end
	end

	wire logic scl_rise = scl_next & ~scl_reg;
	wire logic scl_fall = ~scl_next & scl_reg;
	wire logic start_c  = scl_reg & scl_next & sda_reg & ~sda_next;
	wire logic stop_c   = scl_reg & scl_next & ~sda_reg & sda_next;

	cilr_pkg::cilr_state_t state_reg;
	cilr_pkg::cilr_state_t state_next;
	logic [7:0] shift_reg;
	logic [7:0] shift_next;
	logic [2:0] bit_reg;
	logic [2:0] bit_next;
	logic       rw_reg;
	logic       rw_next;
	logic [7:0] off_reg;
	logic [7:0] off_next;
	logic       sda_out_reg;
	logic       sda_out_next;
	logic       ack_reg;
	logic       ack_next;
	cilr_pkg::cilr_icl_t icl_reg;
	cilr_pkg::cilr_icl_t icl_next;
	logic       mem_wr;
	logic [7:0] mem_rd;
	logic [7:0] rd_byte;

	cilr_regmem u_mem (
		.ref_clk (ref_clk),
		.rst     (rst | reg_reset),
		.wr_en   (mem_wr),
		.wr_addr (off_reg[3:0]),
		.wr_data (shift_reg),
		.rd_addr (off_reg[3:0]),
		.rd_data (mem_rd)
	);

	// Read byte for the current offset
	always_comb begin
		if (off_reg > cilr_pkg::LAST_OFFSET) begin
			rd_byte = cilr_pkg::UNMAPPED_DATA;
		end else if (off_reg == cilr_pkg::ICL_OFFSET) begin
			rd_byte = icl_reg;
		end else begin
			rd_byte = mem_rd;
		end
	end

	always_comb begin
		state_next   = state_reg;
		shift_next   = shift_reg;
		bit_next     = bit_reg;
		rw_next      = rw_reg;
		off_next     = off_reg;
		sda_out_next = sda_out_reg;
		ack_next     = ack_reg;
		icl_next     = icl_reg;
		mem_wr       = 1'b0;
		if (detect.valid) begin
			icl_next.input_current_limit_code = detect.code;
		end
		// A cut byte must not leave a pending acknowledge behind
		if (stop_c) begin
			state_next   = cilr_pkg::ST_IDLE;
			sda_out_next = 1'b1;
			ack_next     = 1'b0;
		end else if (start_c) begin
			state_next   = cilr_pkg::ST_ADDR;
			bit_next     = 3'h0;
			sda_out_next = 1'b1;
			ack_next     = 1'b0;
		end else begin
			case (state_reg)
				cilr_pkg::ST_ADDR, cilr_pkg::ST_OFFS,
				cilr_pkg::ST_WDATA: begin
					if (scl_rise) begin
						shift_next = {shift_reg[6:0], sda_reg};
						bit_next   = bit_reg + 3'h1;
					end
					if (scl_fall && bit_reg == 3'h0 && ack_reg) begin
						ack_next = 1'b0;
						case (state_reg)
							cilr_pkg::ST_ADDR: begin
								rw_next = shift_reg[0];
								if (shift_reg[7:1] == cilr_pkg::SLAVE_ADDR) begin
									sda_out_next = 1'b0;
									state_next   = cilr_pkg::ST_ADDR_ACK;
								end else begin
									state_next = cilr_pkg::ST_IDLE;
								end
							end
							cilr_pkg::ST_OFFS: begin
								off_next     = shift_reg;
								sda_out_next = 1'b0;
								state_next   = cilr_pkg::ST_OFFS_ACK;
							end
							default: begin
								if (off_reg == cilr_pkg::ICL_OFFSET) begin
									icl_next = shift_reg;
								end else if (off_reg <= cilr_pkg::LAST_OFFSET) begin
									mem_wr = 1'b1;
								end
								sda_out_next = 1'b0;
								state_next   = cilr_pkg::ST_WDATA_ACK;
							end
						endcase
					end else if (scl_rise && bit_reg == cilr_pkg::BIT_LAST) begin
						ack_next = 1'b1;
					end
				end
				cilr_pkg::ST_ADDR_ACK, cilr_pkg::ST_OFFS_ACK,
				cilr_pkg::ST_WDATA_ACK: begin
					if (scl_fall) begin
						bit_next = 3'h0;
						if (state_reg == cilr_pkg::ST_ADDR_ACK && rw_reg) begin
							shift_next   = rd_byte;
							sda_out_next = rd_byte[7];
							state_next   = cilr_pkg::ST_RDATA;
						end else begin
							sda_out_next = 1'b1;
							if (state_reg == cilr_pkg::ST_ADDR_ACK) begin
								state_next = cilr_pkg::ST_OFFS;
							end else begin
								state_next = cilr_pkg::ST_WDATA;
							end
							if (state_reg == cilr_pkg::ST_WDATA_ACK) begin
								off_next = step_offset(off_reg);
							end
						end
					end
				end
				cilr_pkg::ST_RDATA: begin
					if (scl_fall) begin
						bit_next = bit_reg + 3'h1;
						if (bit_reg == cilr_pkg::BIT_LAST) begin
							sda_out_next = 1'b1;
							state_next   = cilr_pkg::ST_RDATA_ACK;
						end else begin
							shift_next   = {shift_reg[6:0], 1'b0};
							sda_out_next = shift_reg[6];
						end
					end
				end
				cilr_pkg::ST_RDATA_ACK: begin
					if (scl_rise) begin
						ack_next = ~sda_reg;
						if (~sda_reg) begin
							off_next = step_offset(off_reg);
						end
					end
					if (scl_fall) begin
						bit_next = 3'h0;
						if (ack_reg) begin
							shift_next   = rd_byte;
							sda_out_next = rd_byte[7];
							state_next   = cilr_pkg::ST_RDATA;
						end else begin
							state_next = cilr_pkg::ST_IDLE;
						end
						ack_next = 1'b0;
					end
				end
				default: begin
					sda_out_next = 1'b1;
				end
			endcase
		end
	end

	always_ff @(posedge ref_clk) begin
		if (rst) begin
			state_reg   <= cilr_pkg::ST_IDLE;
			shift_reg   <= 8'h00;
			bit_reg     <= 3'h0;
			rw_reg      <= 1'b0;
			off_reg     <= 8'h00;
			sda_out_reg <= 1'b1;
			ack_reg     <= 1'b0;
		end else begin
			state_reg   <= state_next;
			shift_reg   <= shift_next;
			bit_reg     <= bit_next;
			rw_reg      <= rw_next;
			off_reg     <= off_next;
			sda_out_reg <= sda_out_next;
			ack_reg     <= ack_next;
		end
		if (rst || reg_reset) begin
			icl_reg <= cilr_pkg::ICL_RESET;
		end else begin
			icl_reg <= icl_next;
		end
	end

	// Pin and field outputs, all registered
	always_ff @(posedge ref_clk) begin
		if (rst) begin
			sda_out           <= 1'b1;
			sda_oe_n          <= 1'b1;
			stat_out          <= 1'b1;
			stat_oe_n         <= 1'b1;
			supply_disconnect <= 1'b0;
			icl_out           <= cilr_pkg::ICL_RESET;
		end else begin
			sda_out  <= 1'b0;
			sda_oe_n <= sda_out_reg;
			stat_out <= 1'b0;
			case (icl_reg.status_pin_function_select)
				cilr_pkg::STAT_FOLLOW_CHG: stat_oe_n <= ~charging_active;
				cilr_pkg::STAT_FOLLOW_SET: stat_oe_n <= ~custom_status_on;
				default:                   stat_oe_n <= 1'b1;
			endcase
			supply_disconnect <= icl_reg.high_impedance_input_enable;
			icl_out           <= icl_reg;
		end
	end
endmodule

// file: src/cilr_pkg.sv
// Package: register map, I2C constants and shared types for the register bank
package cilr_pkg;
	localparam logic [6:0] SLAVE_ADDR      = 7'h1a;
	localparam int         REG_COUNT       = 16;
	localparam logic [7:0] LAST_OFFSET     = 8'h0f;
	localparam logic [7:0] UNMAPPED_DATA   = 8'hff;
	localparam logic [7:0] FAULT_OFFSET    = 8'h09;
	localparam logic [7:0] FLAG_OFFSET     = 8'h0e;
	localparam logic [7:0] ICL_OFFSET      = 8'h00;
	localparam logic [7:0] ICL_RESET       = 8'h17;
	localparam logic [7:0] OTHER_RESET     = 8'h00;
	localparam int         HIZ_BIT         = 7;
	localparam int         STAT_SEL_MSB    = 6;
	localparam int         STAT_SEL_LSB    = 5;
	localparam int         ICL_CODE_MSB    = 4;
	localparam int         ICL_CODE_LSB    = 0;
	localparam logic [1:0] STAT_FOLLOW_CHG = 2'h0;
	localparam logic [1:0] STAT_FOLLOW_SET = 2'h1;
	localparam logic [2:0] BIT_LAST        = 3'h7;

	typedef struct packed {
		logic       high_impedance_input_enable;
		logic [1:0] status_pin_function_select;
		logic [4:0] input_current_limit_code;
	} cilr_icl_t;

	typedef struct packed {
		logic       valid;
		logic [4:0] code;
	} cilr_detect_t;

	typedef enum {
		ST_IDLE,
		ST_ADDR,
		ST_ADDR_ACK,
		ST_OFFS,
		ST_OFFS_ACK,
		ST_WDATA,
		ST_WDATA_ACK,
		ST_RDATA,
		ST_RDATA_ACK
	} cilr_state_t;
endpackage

// file: src/cilr_regmem.sv
// Register array for offsets other than zero, with registered read data
module cilr_regmem (
	input  wire logic       ref_clk,
	input  wire logic       rst,
	input  wire logic       wr_en,
	input  wire logic [3:0] wr_addr,
	input  wire logic [7:0] wr_data,
	input  wire logic [3:0] rd_addr,
	output logic      [7:0] rd_data
);
	logic [7:0] mem_reg [cilr_pkg::REG_COUNT];
	logic [7:0] mem_next [cilr_pkg::REG_COUNT];
	logic [7:0] rd_next;

	always_comb begin
		for (int i = 0; i < cilr_pkg::REG_COUNT; i++) begin
			mem_next[i] = mem_reg[i];
		end
		if (wr_en) begin
			mem_next[wr_addr] = wr_data;
		end
		rd_next = mem_reg[rd_addr];
	end

	always_ff @(posedge ref_clk) begin
		for (int i = 0; i < cilr_pkg::REG_COUNT; i++) begin
			if (rst) begin
				mem_reg[i] <= cilr_pkg::OTHER_RESET;
			end else begin
				mem_reg[i] <= mem_next[i];
			end
		end
		if (rst) begin
			rd_data <= cilr_pkg::OTHER_RESET;
		end else begin
			rd_data <= rd_next;
		end
	end
endmodule

// file: verification/cilr_properties.sv
// Concurrent checks on the register bank ports
module cilr_properties (
	input wire logic                   ref_clk,
	input wire logic                   rst,
	input wire logic                   reg_reset,
	input wire logic                   scl_in,
	input wire cilr_pkg::cilr_detect_t detect,
	input wire logic                   charging_active,
	input wire logic                   custom_status_on,
	input wire logic                   stat_oe_n,
	input wire logic                   supply_disconnect,
	input wire cilr_pkg::cilr_icl_t    icl_out
);
	timeunit 1ns;
	timeprecision 1ns;
	default clocking cb @(posedge ref_clk); endclocking
	default disable iff (rst);
	sequence float_mode;
		icl_out[6] [*3];
	endsequence
	sequence quiet_bus;
		(scl_in && !reg_reset && !detect.valid) [*8];
	endsequence
	restore_val_a: assert property (
		reg_reset |-> ##[1:2] icl_out == 8'h17) else $error("no default");
	hiz_set_a: assert property (
		icl_out[7] |-> ##[0:1] supply_disconnect) else $error("no hiz");
	hiz_clear_a: assert property (
		!icl_out[7] |-> ##[0:1] !supply_disconnect) else $error("hiz");
	stat_float_a: assert property (
		float_mode |-> stat_oe_n) else $error("pin not floating");
	stat_charge_a: assert property (
		(icl_out[6:5] == 2'h0 && charging_active) [*3] |-> !stat_oe_n)
		else $error("pin not charge");
	stat_custom_a: assert property (
		(icl_out[6:5] == 2'h1 && custom_status_on) [*3] |-> !stat_oe_n)
		else $error("pin not custom");
	detect_load_a: assert property (
		detect.valid |-> ##2 icl_out[4:0] == $past(detect.code, 2))
		else $error("detect not loaded");
	field_hold_a: assert property (
		quiet_bus |-> $stable(icl_out)) else $error("field moved");
endmodule

// file: verification/cilr_host.sv
// I2C host controller model driving the bus
module cilr_host (
	input  wire logic ref_clk,
	input  wire logic sda_lvl,
	output logic      scl,
	output logic      sda
);
	timeunit 1ns;
	timeprecision 1ns;
	int hp = 8;
	initial begin
		scl = 1'b1;
		sda = 1'b1;
	end
	task automatic hw();
		repeat (hp) @(negedge ref_clk);
	endtask
	task automatic start();
		sda = 1'b1;
		hw();
		scl = 1'b1;
		hw();
		sda = 1'b0;
		hw();
		scl = 1'b0;
	endtask
	task automatic stop();
		sda = 1'b0;
		hw();
		scl = 1'b1;
		hw();
		sda = 1'b1;
		hw();
	endtask
	task automatic bitx(input logic b, output logic r);
		sda = b;
		hw();
		scl = 1'b1;
		repeat (hp / 2) @(negedge ref_clk);
		r = sda_lvl;
		repeat (hp / 2) @(negedge ref_clk);
		scl = 1'b0;
	endtask
	// Eight bits MSB first, then the acknowledge slot
	task automatic xfer(input logic [7:0] d, input logic ai,
		output logic [7:0] q, output logic ao);
		for (int i = 7; i >= 0; i--) begin
			bitx(d[i], q[i]);
		end
		bitx(ai, ao);
	endtask
endmodule

// file: verification/tb_top.sv
// Testbench for the input current limit register bank
module tb_top;
	timeunit 1ns;
	timeprecision 1ns;
	logic                   ref_clk, rst, reg_reset, scl, sda_h, a;
	logic                   charging_active, custom_status_on, sda_out;
	logic                   sda_oe_n, stat_out, stat_oe_n, supply_disconnect;
	logic [7:0]             q;
	logic [4:0]             code;
	wire logic              sda_lvl;
	cilr_pkg::cilr_detect_t detect;
	cilr_pkg::cilr_icl_t    icl_out;
	int                     error_cnt, comparisons, cyc, s;
	int                     mdl [16];
	assign sda_lvl = sda_h & (sda_oe_n | sda_out);
	cilr_host host (.ref_clk, .sda_lvl, .scl, .sda(sda_h));
	cilr_top DUT (.ref_clk, .rst, .reg_reset, .scl_in(scl), .sda_in(sda_lvl),
		.detect, .charging_active, .custom_status_on, .sda_out, .sda_oe_n,
		.stat_out, .stat_oe_n, .supply_disconnect, .icl_out);
	initial begin
		ref_clk = 1'b0;
		forever #10 ref_clk = ~ref_clk;
	end
	task automatic close_out();
		$display("checks %0d mismatches %0d", comparisons, error_cnt);
		if (error_cnt == 0 && comparisons > 0) begin
			$display("== PASSED ==");
		end else begin
			$display("== FAILED ==");
		end
		$finish;
	endtask
	always @(posedge ref_clk) begin
		cyc++;
		if (cyc == 60000) begin
			error_cnt++;
			close_out();
		end
	end
	task automatic chk(input logic [7:0] g, input int e, input string m);
		comparisons++;
		if (g !== 8'(e)) begin
			error_cnt++;
			$display("[FAIL] %0t %s got %h exp %h", $time, m, g, 8'(e));
		end
	endtask
	function automatic int nxt(input int o);
		return (o == 8 || o == 13) ? o + 2 : o + 1;
	endfunction
	task automatic start_addr(input int o);
		host.start();
		host.xfer({7'h1a, 1'b0}, 1'b1, q, a);
		chk({7'h0, a}, 0, "addr ack");
		host.xfer(o[7:0], 1'b1, q, a);
	endtask
	task automatic wr(input int o, input int n, input logic [7:0] d0);
		logic [7:0] d;
		d = d0;
		start_addr(o);
		repeat (n) begin
			host.xfer(d, 1'b1, q, a);
			if (o < 16) mdl[o] = d;
			o = nxt(o);
			d = 8'($urandom);
		end
		host.stop();
	endtask
	task automatic rd(input int o, input int n);
		start_addr(o);
		host.start();
		host.xfer({7'h1a, 1'b1}, 1'b1, q, a);
		for (int i = 1; i <= n; i++) begin
			host.xfer(8'hff, i == n, q, a);
			chk(q, o < 16 ? mdl[o] : 255, "read");
			o = nxt(o);
		end
		host.stop();
	endtask
	initial begin
		rst = 1'b1;
		reg_reset = 1'b0;
		detect = '0;
		charging_active = 1'b1;
		custom_status_on = 1'b0;
		s = $urandom(81);
		mdl = '{default: 0};
		mdl[0] = 'h17;
		repeat (2) @(negedge ref_clk);
		rst = 1'b0;
		repeat (6) @(negedge ref_clk);
		chk(icl_out, 'h17, "reset");
		chk({7'h0, supply_disconnect}, 0, "hiz reset");
		chk({7'h0, stat_oe_n}, 0, "stat reset");
		host.start();
		host.xfer({7'h1b, 1'b0}, 1'b1, q, a);
		chk({7'h0, a}, 1, "foreign addr");
		host.stop();
		rd(0, 1);
		$display("reset and address test done");
		for (int m = 0; m < 8; m++) begin
			charging_active = m[0];
			custom_status_on = !m[0];
			wr(0, 1, {m[2] ^ m[0], m[2:1], 5'($urandom)});
			repeat (4) @(negedge ref_clk);
			chk(icl_out, mdl[0], "limit");
			chk({7'h0, supply_disconnect}, mdl[0] >> 7, "hiz");
			chk({7'h0, stat_oe_n}, m < 4 ? m[0] ^ (m < 2) : 1, "st");
			chk({7'h0, stat_out}, 0, "st level");
		end
		$display("field test done");
		wr(8, 3, 8'($urandom));
		wr(13, 3, 8'($urandom));
		host.hp = 12;
		rd(7, 5);
		host.hp = 8;
		rd(13, 4);
		$display("multi byte test done");
		code = 5'($urandom);
		detect = {1'b1, code};
		@(negedge ref_clk);
		detect = '0;
		repeat (3) @(negedge ref_clk);
		mdl[0] = (mdl[0] & 'he0) | code;
		chk(icl_out, mdl[0], "detect");
		wr(0, 1, 8'($urandom));
		repeat (50) @(negedge ref_clk);
		chk(icl_out, mdl[0], "host write");
		$display("detect test done");
		reg_reset = 1'b1;
		@(negedge ref_clk);
		reg_reset = 1'b0;
		mdl = '{default: 0};
		mdl[0] = 'h17;
		repeat (3) @(negedge ref_clk);
		chk(icl_out, mdl[0], "restore");
		rd(0, 3);
		rd(8, 2);
		$display("restore test done");
		close_out();
	end
endmodule
bind cilr_top cilr_properties u_chk (.ref_clk, .rst, .reg_reset, .scl_in,
	.detect, .charging_active, .custom_status_on, .stat_oe_n,
	.supply_disconnect, .icl_out);
